// ### rtl/fswp_pkg.sv
// Constants, types and command codes for the flash status and write-protect block
package fswp_pkg;

    // Serial command codes
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS2_READ = 8'h35;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] CMD_WRITE_FORBID = 8'h04;
    localparam logic [7:0] CMD_BYTE_WRITE = 8'h02;
    localparam logic [7:0] CMD_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] CMD_BLOCK_WIPE = 8'hD8;
    localparam logic [7:0] CMD_BLOCK_WIPE_ALT = 8'h52;
    localparam logic [7:0] CMD_CHIP_WIPE = 8'hC7;
    localparam logic [7:0] CMD_CHIP_WIPE_ALT = 8'h60;

    // Frame lengths in serial clocks
    localparam logic [5:0] LEN_CMD = 6'h08;
    localparam logic [5:0] LEN_STATUS_WRITE = 6'h10;
    localparam logic [5:0] LEN_ADDR_CMD = 6'h20;
    localparam logic [5:0] LEN_BYTE_WRITE_MIN = 6'h28;
    localparam logic [5:0] LEN_MAX = 6'h3F;

    // Status register bit positions
    localparam int BUSY_POS = 0;
    localparam int PERMIT_POS = 1;
    localparam int LEVEL_LSB = 2;
    localparam int LEVEL_MSB = 4;
    localparam int LOCK_POS = 7;

    // Array geometry, as address bit counts
    localparam logic [4:0] ADDR_BITS = 5'h13;
    localparam logic [4:0] PAGE_BITS = 5'h08;
    localparam logic [4:0] SECTOR_BITS = 5'h0C;
    localparam logic [4:0] BLOCK_BITS = 5'h10;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] LEVEL_NONE = 3'h0;

    // Self-timed cycle durations
    localparam int CLK_MHZ = 100;
    localparam int T_STATUS_WRITE_US = 10000;
    localparam int T_BYTE_WRITE_US = 2000;
    localparam int T_SECTOR_WIPE_US = 200000;
    localparam int T_BLOCK_WIPE_US = 500000;
    localparam int T_CHIP_WIPE_US = 4000000;
    localparam int STATUS_WRITE_CYCLES = T_STATUS_WRITE_US * CLK_MHZ;
    localparam int BYTE_WRITE_CYCLES = T_BYTE_WRITE_US * CLK_MHZ;
    localparam int SECTOR_WIPE_CYCLES = T_SECTOR_WIPE_US * CLK_MHZ;
    localparam int BLOCK_WIPE_CYCLES = T_BLOCK_WIPE_US * CLK_MHZ;
    localparam int CHIP_WIPE_CYCLES = T_CHIP_WIPE_US * CLK_MHZ;

    // Non-volatile protection bits
    typedef struct packed {
        logic status_lock;
        logic top_or_bottom;
        logic small_unit_protect;
        logic [2:0] protect_level;
    } fswp_nv_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_STATUS = 3'h1,
        OP_BYTE_WRITE = 3'h2,
        OP_SECTOR = 3'h3,
        OP_BLOCK = 3'h4,
        OP_CHIP = 3'h5
    } fswp_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_DONE = 2'h3
    } fswp_state_t;

endpackage : fswp_pkg

// ### rtl/fswp_status_protect.sv
// Status register, write-enable latch and write protection of a serial flash
//
// Functional notes
// - 05h returns status one, 35h status two
// - Status reads served even during busy cycles
// - Status byte repeats while select stays low
// - Busy flag b0, set during timed cycles
// - Busy ignores all but status reads
// - Cycle end clears busy flag
// - Write permit latch b1, set by permit
// - Latch cleared at power-up, forbid, completions
// - Protect level bits b4..b2, default zero
// - Top or bottom bit, default zero
// - Small unit bit selects sectors or blocks
// - Status lock bit b7, default zero
// - Status write needs latch set, one byte
// - Write keeps b6,b5,b1,b0; b6,b5 read zero
// - Select must rise after data byte
// - Valid status write starts timed busy cycle
// - Lock clear: write allowed with latch
// - Lock set, pin high: write allowed
// - Lock set, pin low: hardware lock
// - Lock entered either order, left pin high
// - Writes to protected region refused
// - MSB first, sampled on rising edge
// - Write commands need whole byte count
`timescale 1ns/1ns

module fswp_status_protect
    import fswp_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_CYCLES_P = STATUS_WRITE_CYCLES,
    parameter int unsigned BYTE_WRITE_CYCLES_P = BYTE_WRITE_CYCLES,
    parameter int unsigned SECTOR_WIPE_CYCLES_P = SECTOR_WIPE_CYCLES,
    parameter int unsigned BLOCK_WIPE_CYCLES_P = BLOCK_WIPE_CYCLES,
    parameter int unsigned CHIP_WIPE_CYCLES_P = CHIP_WIPE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in_pin,
    input wire logic wp_n,
    input wire fswp_nv_t nv_stored,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output fswp_nv_t nv_store,
    output logic nv_store_we,
    output logic hardware_lock_state,
    output logic [7:0] status_view,
    output logic op_start,
    output fswp_op_t op_kind
);

    // ---------------- Serial clock domain ----------------
    logic in_frame_r;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [2:0] phase_r;
    logic [2:0] phase_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] cmd_r;
    logic [7:0] data_r;
    logic [23:0] addr_r;
    logic [15:0] stat_meta_r;
    logic [15:0] stat_sync_r;
    logic [7:0] tx_r;
    logic rd_cmd;
    logic [7:0] status2_r;

    // Frame marker, cleared while select is high so the first edge restarts counts
    always_ff @(posedge sclk or negedge reset_n or posedge cs_n) begin
        if (!reset_n) begin
            in_frame_r <= 1'b0;
        end else if (cs_n) begin
            in_frame_r <= 1'b0;
        end else begin
            in_frame_r <= 1'b1;
        end
    end

    always_comb begin
        shift_nxt = {shift_r[6:0], serial_in_pin};
        if (!in_frame_r) begin
            cnt_nxt = 6'h01;
            phase_nxt = 3'h1;
        end else begin
            cnt_nxt = (cnt_r == LEN_MAX) ? cnt_r : cnt_r + 6'h01;
            phase_nxt = phase_r + 3'h1;
        end
    end

    // Frame contents stay still after select rises; the core reads them then
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 6'h00;
            phase_r <= 3'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            data_r <= 8'h00;
            addr_r <= 24'h00_0000;
        end else begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            shift_r <= shift_nxt;
            if (cnt_nxt == LEN_CMD) begin
                cmd_r <= shift_nxt;
            end
            if (cnt_nxt == LEN_STATUS_WRITE) begin
                data_r <= shift_nxt;
            end
            if (cnt_nxt > LEN_CMD && cnt_nxt <= LEN_ADDR_CMD) begin
                addr_r <= {addr_r[22:0], serial_in_pin};
            end
        end
    end

    // Status words cross as independent slow flags
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            stat_meta_r <= 16'h0000;
            stat_sync_r <= 16'h0000;
        end else begin
            stat_meta_r <= {status2_r, status_view};
            stat_sync_r <= stat_meta_r;
        end
    end

    assign rd_cmd = (cmd_r == CMD_STATUS_READ) || (cmd_r == CMD_STATUS2_READ);

    // Read-out shifts on falling edges, reloading a fresh byte every eighth bit
    always_ff @(negedge sclk or negedge reset_n or posedge cs_n) begin
        if (!reset_n) begin
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            tx_r <= 8'h00;
        end else if (cs_n) begin
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            tx_r <= 8'h00;
        end else if (rd_cmd && cnt_r >= LEN_CMD) begin
            serial_out_oe <= 1'b1;
            if (phase_r == 3'h0) begin
                if (cmd_r == CMD_STATUS2_READ) begin
                    tx_r <= stat_sync_r[15:8];
                    serial_out_pin <= stat_sync_r[15];
                end else begin
                    tx_r <= stat_sync_r[7:0];
                    serial_out_pin <= stat_sync_r[7];
                end
            end else begin
                serial_out_pin <= tx_r[3'h7 - phase_r];
            end
        end
    end

    // ---------------- Core clock domain ----------------
    logic cs_meta_r;
    logic cs_sync_r;
    logic cs_prev_r;
    logic wp_meta_r;
    logic wp_sync_r;
    logic frame_end;
    logic load_done_r;
    fswp_nv_t nv_r;
    fswp_nv_t pend_r;
    logic permit_r;
    fswp_state_t st_r;
    logic [31:0] timer_r;
    fswp_op_t kind_r;
    fswp_op_t req_kind;
    logic set_permit;
    logic clr_permit;
    logic aligned;
    logic busy;
    logic hw_lock_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
            cs_prev_r <= 1'b1;
            wp_meta_r <= 1'b1;
            wp_sync_r <= 1'b1;
        end else begin
            cs_meta_r <= cs_n;
            cs_sync_r <= cs_meta_r;
            cs_prev_r <= cs_sync_r;
            wp_meta_r <= wp_n;
            wp_sync_r <= wp_meta_r;
        end
    end

    assign frame_end = cs_sync_r && !cs_prev_r;
    assign aligned = (phase_r == 3'h0);
    assign busy = (st_r != ST_IDLE);

    // Unit touched by an address overlaps the protected end of the array
    function automatic logic region_locked(input fswp_nv_t nv, input logic [23:0] a,
                                           input logic [4:0] unit_bits);
        logic [4:0] lg;
        logic [18:0] size_m1;
        logic [18:0] unit_m1;
        logic [18:0] first;
        logic [18:0] last;
        lg = (nv.small_unit_protect ? SECTOR_BITS : BLOCK_BITS)
             + {2'b00, nv.protect_level} - 5'h01;
        size_m1 = (19'h0_0001 << lg) - 19'h0_0001;
        unit_m1 = (19'h0_0001 << unit_bits) - 19'h0_0001;
        first = a[18:0] & ~unit_m1;
        last = first | unit_m1;
        if (nv.protect_level == LEVEL_NONE) begin
            region_locked = 1'b0;
        end else if (lg >= ADDR_BITS) begin
            region_locked = 1'b1;
        end else if (nv.top_or_bottom) begin
            region_locked = (first <= size_m1);
        end else begin
            region_locked = (last >= ~size_m1);
        end
    endfunction : region_locked

    // Command decode when select rises
    always_comb begin
        req_kind = OP_NONE;
        set_permit = 1'b0;
        clr_permit = 1'b0;
        if (frame_end && !busy && load_done_r && aligned) begin
            if (cmd_r == CMD_WRITE_PERMIT && cnt_r == LEN_CMD) begin
                set_permit = 1'b1;
            end else if (cmd_r == CMD_WRITE_FORBID && cnt_r == LEN_CMD) begin
                clr_permit = 1'b1;
            end else if (cmd_r == CMD_STATUS_WRITE && cnt_r == LEN_STATUS_WRITE) begin
                if (permit_r && !hw_lock_r) begin
                    req_kind = OP_STATUS;
                end
            end else if (!permit_r) begin
                req_kind = OP_NONE;
            end else if (cmd_r == CMD_BYTE_WRITE && cnt_r >= LEN_BYTE_WRITE_MIN) begin
                if (!region_locked(nv_r, addr_r, PAGE_BITS)) begin
                    req_kind = OP_BYTE_WRITE;
                end
            end else if (cmd_r == CMD_SECTOR_WIPE && cnt_r == LEN_ADDR_CMD) begin
                if (!region_locked(nv_r, addr_r, SECTOR_BITS)) begin
                    req_kind = OP_SECTOR;
                end
            end else if ((cmd_r == CMD_BLOCK_WIPE || cmd_r == CMD_BLOCK_WIPE_ALT)
                         && cnt_r == LEN_ADDR_CMD) begin
                if (!region_locked(nv_r, addr_r, BLOCK_BITS)) begin
                    req_kind = OP_BLOCK;
                end
            end else if ((cmd_r == CMD_CHIP_WIPE || cmd_r == CMD_CHIP_WIPE_ALT)
                         && cnt_r == LEN_CMD) begin
                if (nv_r.protect_level == LEVEL_NONE) begin
                    req_kind = OP_CHIP;
                end
            end
        end
    end

    // Self-timed cycle sequencer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_IDLE;
            timer_r <= 32'h0000_0000;
            kind_r <= OP_NONE;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (req_kind != OP_NONE) begin
                        st_r <= ST_RUN;
                        kind_r <= req_kind;
                        case (req_kind)
                            OP_STATUS: timer_r <= 32'(STATUS_WRITE_CYCLES_P - 1);
                            OP_BYTE_WRITE: timer_r <= 32'(BYTE_WRITE_CYCLES_P - 1);
                            OP_SECTOR: timer_r <= 32'(SECTOR_WIPE_CYCLES_P - 1);
                            OP_BLOCK: timer_r <= 32'(BLOCK_WIPE_CYCLES_P - 1);
                            default: timer_r <= 32'(CHIP_WIPE_CYCLES_P - 1);
                        endcase
                    end
                end
                ST_RUN: begin
                    if (timer_r == 32'h0000_0000) begin
                        st_r <= ST_DONE;
                    end else begin
                        timer_r <= timer_r - 32'h0000_0001;
                    end
                end
                ST_DONE: begin
                    st_r <= ST_IDLE;
                    kind_r <= OP_NONE;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Write permit latch
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            permit_r <= 1'b0;
        end else if (set_permit) begin
            permit_r <= 1'b1;
        end else if (clr_permit || st_r == ST_DONE) begin
            permit_r <= 1'b0;
        end
    end

    // Non-volatile bits: loaded once after reset; lock and level bits rewritten by status writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_done_r <= 1'b0;
            nv_r <= '0;
            pend_r <= '0;
            nv_store_we <= 1'b0;
        end else begin
            nv_store_we <= 1'b0;
            if (!load_done_r) begin
                load_done_r <= 1'b1;
                nv_r <= nv_stored;
            end else if (req_kind == OP_STATUS) begin
                pend_r.status_lock <= data_r[LOCK_POS];
                pend_r.protect_level <= data_r[LEVEL_MSB:LEVEL_LSB];
            end else if (st_r == ST_DONE && kind_r == OP_STATUS) begin
                nv_r.status_lock <= pend_r.status_lock;
                nv_r.protect_level <= pend_r.protect_level;
                nv_store_we <= 1'b1;
            end
        end
    end

    assign nv_store = nv_r;

    // Lock state follows whichever of lock bit and pin comes last
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hw_lock_r <= 1'b0;
        end else begin
            hw_lock_r <= nv_r.status_lock && !wp_sync_r;
        end
    end

    assign hardware_lock_state = hw_lock_r;

    // Published status words; b6 and b5 always read zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_view <= STATUS_RESET;
            status2_r <= STATUS_RESET;
        end else begin
            status_view <= {nv_r.status_lock, 2'b00, nv_r.protect_level,
                            permit_r, busy};
            status2_r <= {6'h00, nv_r.small_unit_protect, nv_r.top_or_bottom};
        end
    end

    // Array operation strobe for the array sequencer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_start <= 1'b0;
            op_kind <= OP_NONE;
        end else begin
            op_start <= (req_kind != OP_NONE);
            op_kind <= req_kind;
        end
    end

endmodule : fswp_status_protect

// ### bench/fswp_status_protect_monitor.sv
// Checker for the flash status and write-protect block
`timescale 1ns/1ns
module fswp_status_protect_monitor
    import fswp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire fswp_nv_t nv_store,
    input wire logic nv_store_we,
    input wire logic hardware_lock_state,
    input wire logic [7:0] status_view,
    input wire logic op_start,
    input wire fswp_op_t op_kind
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_lock_cond;
        (nv_store.status_lock && !wp_n) [*4];
    endsequence
    sequence s_status_start;
        op_start && op_kind == OP_STATUS;
    endsequence

    chk_out_idle: assert property (cs_n |-> !serial_out_oe && !serial_out_pin)
        else $error("serial output active while deselected");
    chk_kind_valid: assert property ((op_kind != OP_NONE) == op_start)
        else $error("operation kind and start pulse disagree");
    chk_start_idle: assert property (op_start |-> !status_view[0])
        else $error("command started while busy");
    chk_start_permit: assert property (op_start |-> status_view[1])
        else $error("command started without write permit");
    chk_busy_rise: assert property (op_start |-> ##[1:2] status_view[0])
        else $error("busy flag not raised after start");
    chk_busy_run: assert property (s_status_start |-> ##3 status_view[0] [*8])
        else $error("busy flag dropped early in status write");
    chk_done_clear: assert property (nv_store_we |-> ##[1:3] status_view[1:0] == 2'h0)
        else $error("busy or permit left set after completion");
    chk_lock_enter: assert property (s_lock_cond |-> hardware_lock_state)
        else $error("hardware lock not entered");
    chk_lock_exit: assert property (wp_n [*4] |-> !hardware_lock_state)
        else $error("hardware lock kept with pin high");
    chk_lock_freeze: assert property (hardware_lock_state && op_start |-> op_kind != OP_STATUS)
        else $error("status write accepted under hardware lock");
    chk_view_track: assert property (##1 {status_view[7:2]} ==
            {$past(nv_store.status_lock), 2'h0, $past(nv_store.protect_level)})
        else $error("status byte does not match stored bits");
endmodule : fswp_status_protect_monitor

bind fswp_status_protect fswp_status_protect_monitor u_mon (
    .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .wp_n(wp_n),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .nv_store(nv_store),
    .nv_store_we(nv_store_we), .hardware_lock_state(hardware_lock_state),
    .status_view(status_view), .op_start(op_start), .op_kind(op_kind)
);

// ### bench/fswp_host_model.sv
// Host serial controller model driving the flash link
`timescale 1ns/1ns
module fswp_host_model (
    output logic sclk,
    output logic cs_n,
    output logic serial_in_pin,
    input wire logic serial_out_pin
);
    localparam int HALF = 16;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in_pin = 1'b1;
    end

    // Clock stands low outside frames; read bits collected after the command byte
    task automatic frame(input logic [39:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        #3;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in_pin = (i < 40) ? tx[39 - i] : 1'b0;
            #HALF sclk = 1'b1;
            if (i >= 8) rx = {rx[14:0], serial_out_pin};
            #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        serial_in_pin = ~serial_in_pin;
    endtask : frame
endmodule : fswp_host_model

// ### bench/tb_top.sv
// Self-checking bench for the flash status and write-protect block
`timescale 1ns/1ns
module tb_top;
    import fswp_pkg::*;
    logic core_clk, reset_n, wp_n, sclk, cs_n, serial_in_pin;
    logic serial_out_pin, serial_out_oe, nv_store_we, hardware_lock_state, op_start;
    fswp_nv_t nv_stored, nv_store;
    fswp_op_t op_kind, last_kind;
    logic [7:0] status_view;
    logic [15:0] rx;
    int failures, n_tests, n_ops, n_we, exp_ops;

    fswp_status_protect #(
        .STATUS_WRITE_CYCLES_P(200), .BYTE_WRITE_CYCLES_P(400), .SECTOR_WIPE_CYCLES_P(40),
        .BLOCK_WIPE_CYCLES_P(40), .CHIP_WIPE_CYCLES_P(40)
    ) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
        .serial_in_pin(serial_in_pin), .wp_n(wp_n), .nv_stored(nv_stored),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .nv_store(nv_store),
        .nv_store_we(nv_store_we), .hardware_lock_state(hardware_lock_state),
        .status_view(status_view), .op_start(op_start), .op_kind(op_kind)
    );
    fswp_host_model u_host (
        .sclk(sclk), .cs_n(cs_n), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (op_start === 1'b1) begin
            n_ops <= n_ops + 1;
            last_kind <= op_kind;
        end
        if (nv_store_we === 1'b1) n_we <= n_we + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic xfer(input logic [39:0] tx, input int n);
        u_host.frame(tx, n, rx);
        repeat (8) @(posedge core_clk);
    endtask : xfer

    task automatic permit;
        xfer({CMD_WRITE_PERMIT, 32'h0000_0000}, 8);
    endtask : permit

    task automatic sw(input logic [7:0] d, input int n);
        xfer({CMD_STATUS_WRITE, d, 24'h00_0000}, n);
    endtask : sw

    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        xfer({op, 32'h0000_0000}, 24);
        check(rx, {exp, exp});
    endtask : rd

    task automatic ops(input int add, input fswp_op_t k);
        exp_ops += add;
        check(16'(n_ops), 16'(exp_ops));
        if (add > 0) check(16'(last_kind), 16'(k));
    endtask : ops

    task automatic wait_idle;
        int i;
        for (i = 0; i < 1000 && status_view[0] !== 1'b0; i++) @(posedge core_clk);
        if (i == 1000) begin
            failures++;
            wrap_up();
        end
        repeat (3) @(posedge core_clk);
    endtask : wait_idle

    task automatic t_reset;
        check(16'(nv_store), 16'(nv_stored));
        check(status_view, 8'h04);
        rd(CMD_STATUS_READ, 8'h04);
        rd(CMD_STATUS2_READ, 8'h03);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_protect;
        permit();
        check(status_view, 8'h06);
        xfer({CMD_BYTE_WRITE, 24'h00_0100, 8'hA5}, 40);
        ops(0, OP_NONE);
        xfer({CMD_CHIP_WIPE, 32'h0000_0000}, 8);
        ops(0, OP_NONE);
        xfer({CMD_BYTE_WRITE, 24'h00_1000, 8'hA5}, 40);
        ops(1, OP_BYTE_WRITE);
        rd(CMD_STATUS_READ, 8'h07);
        xfer({CMD_BYTE_WRITE, 24'h00_2000, 8'hA5}, 40);
        wait_idle();
        ops(0, OP_NONE);
        check(status_view, 8'h04);
        $display("t_protect done");
    endtask : t_protect

    task automatic t_status;
        permit();
        sw(8'h63, 16);
        ops(1, OP_STATUS);
        rd(CMD_STATUS_READ, 8'h07);
        wait_idle();
        check(16'(n_we), 16'h0001);
        check(16'(nv_store), 16'h0018);
        check(status_view, 8'h00);
        sw(8'h1C, 16);
        ops(0, OP_NONE);
        permit();
        sw(8'h1C, 12);
        ops(0, OP_NONE);
        sw(8'h1C, 24);
        ops(0, OP_NONE);
        check(status_view, 8'h02);
        xfer({CMD_WRITE_FORBID, 32'h0000_0000}, 8);
        check(status_view, 8'h00);
        $display("t_status done");
    endtask : t_status

    task automatic t_lock;
        @(posedge core_clk) wp_n <= 1'b0;
        permit();
        sw(8'h88, 16);
        ops(1, OP_STATUS);
        wait_idle();
        check(status_view, 8'h88);
        check(hardware_lock_state, 1'b1);
        permit();
        sw(8'h00, 16);
        ops(0, OP_NONE);
        check(status_view, 8'h8A);
        @(posedge core_clk) wp_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(hardware_lock_state, 1'b0);
        sw(8'h80, 16);
        ops(1, OP_STATUS);
        wait_idle();
        @(posedge core_clk) wp_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        check(hardware_lock_state, 1'b1);
        @(posedge core_clk) wp_n <= 1'b1;
        permit();
        xfer({CMD_CHIP_WIPE, 32'h0000_0000}, 8);
        ops(1, OP_CHIP);
        wait_idle();
        check(status_view, 8'h80);
        $display("t_lock done");
    endtask : t_lock

    initial begin
        reset_n = 1'b0;
        wp_n = 1'b1;
        nv_stored = 6'h19;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        t_reset();
        t_protect();
        t_status();
        t_lock();
        wrap_up();
    end
endmodule : tb_top
